// ===== hdl/lpcs_params.svh
`ifndef LPCS_PARAMS_SVH
`define LPCS_PARAMS_SVH

// register indices; byte address is four times the index
`define LPCS_IDX_PIN_CFG    10'h06b
`define LPCS_IDX_SOFT_TRIG  10'h06c
`define LPCS_IDX_LP_CTRL    10'h06e
`define LPCS_IDX_GAIN       10'h07a
`define LPCS_IDX_BG_CTRL    10'h020
`define LPCS_IDX_STATUS     10'h021

// reset values
`define LPCS_RST_PIN_CFG    8'h00
`define LPCS_RST_SOFT_TRIG  8'h01
`define LPCS_RST_LP_CTRL    8'h88
`define LPCS_RST_GAIN       8'h00
`define LPCS_RST_BG_CTRL    8'h00

// field positions
`define LPCS_SRC_SEL_BIT    0
`define LPCS_SOFT_TRIG_BIT  0
`define LPCS_SLEEP_HI       7
`define LPCS_SLEEP_LO       5
`define LPCS_WAKE_HI        4
`define LPCS_WAKE_LO        3
`define LPCS_MODE_BIT       1
`define LPCS_LP_ON_BIT      0
`define LPCS_BG_ON_BIT      0

// sleep and settle lengths in converter clock periods
`define LPCS_SLEEP_0        41'd1152
`define LPCS_SLEEP_1        41'd4194432
`define LPCS_SLEEP_2        41'd33554560
`define LPCS_SLEEP_3        41'd268435584
`define LPCS_SLEEP_4        41'd2147483776
`define LPCS_SLEEP_5        41'd17179869312
`define LPCS_SLEEP_6        41'd137438953600
`define LPCS_SLEEP_7        41'd1099511627904
`define LPCS_WAKE_0         41'd1152
`define LPCS_WAKE_1         41'd33554560
`define LPCS_WAKE_2         41'd268435584
`define LPCS_WAKE_3         41'd2147483776

`endif

// ===== hdl/lpcs_pkg.sv
package lpcs_pkg;

  typedef enum logic [1:0] {
    LPCS_IDLE  = 2'b00,
    LPCS_SLEEP = 2'b01,
    LPCS_WAKE  = 2'b10,
    LPCS_CAL   = 2'b11
  } lpcs_state_e;

  typedef logic [40:0] lpcs_cnt_t;

endpackage

// ===== hdl/lpcs_top.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "lpcs_params.svh"

// Contract
// - select 0: software bit drives trigger
// - sleep code picks sleep length
// - wake code picks settle length
// - mode 0: timed sleep, no trigger
// - mode 1: trigger high sleeps, low wakes
// - low power needs background calibration on
// - control register at 0x6e, reset 0x88
// - gain trim loaded from fuse, writable
// - select 1: pin drives trigger
module lpcs_top
  import lpcs_pkg::*;
#(
  parameter lpcs_cnt_t P_SLEEP_1 = `LPCS_SLEEP_1,
  parameter lpcs_cnt_t P_SLEEP_2 = `LPCS_SLEEP_2,
  parameter lpcs_cnt_t P_SLEEP_3 = `LPCS_SLEEP_3,
  parameter lpcs_cnt_t P_SLEEP_4 = `LPCS_SLEEP_4,
  parameter lpcs_cnt_t P_SLEEP_5 = `LPCS_SLEEP_5,
  parameter lpcs_cnt_t P_SLEEP_6 = `LPCS_SLEEP_6,
  parameter lpcs_cnt_t P_SLEEP_7 = `LPCS_SLEEP_7,
  parameter lpcs_cnt_t P_WAKE_1  = `LPCS_WAKE_1,
  parameter lpcs_cnt_t P_WAKE_2  = `LPCS_WAKE_2,
  parameter lpcs_cnt_t P_WAKE_3  = `LPCS_WAKE_3
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXTERNAL_TRIGGER_PIN,
  input  wire logic [7:0]  FUSE_GAIN,
  input  wire logic        CAL_DONE,
  output logic             CAL_TRIGGER,
  output logic             CORE_SLEEP,
  output logic             CORE_SETTLE,
  output logic             CORE_CAL_REQ,
  output logic [7:0]       CORE_GAIN
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger pin synchroniser

  logic       pin_s1_r;
  logic       pin_s2_r;
  logic       pin_s3_r;
  logic       pin_r;
  logic       pin_nxt;

  always_comb begin
    pin_nxt = pin_r;
    // a change counts only once two stages agree
    if (pin_s2_r == pin_s3_r) begin
      pin_nxt = pin_s3_r;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      pin_r    <= 1'b0;
    end else begin
      pin_s1_r <= EXTERNAL_TRIGGER_PIN;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= pin_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and apb slave

  logic [7:0]  pin_cfg_r;
  logic [7:0]  pin_cfg_nxt;
  logic [7:0]  soft_trig_r;
  logic [7:0]  soft_trig_nxt;
  logic [7:0]  lp_ctrl_r;
  logic [7:0]  lp_ctrl_nxt;
  logic [7:0]  gain_r;
  logic [7:0]  gain_nxt;
  logic [7:0]  bg_ctrl_r;
  logic [7:0]  bg_ctrl_nxt;
  logic        fuse_done_r;
  logic        fuse_done_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic        trig_r;
  logic        trig_nxt;
  lpcs_state_e state_r;
  lpcs_state_e state_nxt;
  logic [9:0]  idx;
  logic [8:0]  rd_hit;
  logic        wr_go;

  function automatic logic [8:0] rd_mux(input logic [9:0] a,
                                        input logic [7:0] stat);
    logic [8:0] r;
    r = 9'h000;
    if (a == `LPCS_IDX_PIN_CFG) begin
      r = {1'b1, pin_cfg_r};
    end else if (a == `LPCS_IDX_SOFT_TRIG) begin
      r = {1'b1, soft_trig_r};
    end else if (a == `LPCS_IDX_LP_CTRL) begin
      r = {1'b1, lp_ctrl_r};
    end else if (a == `LPCS_IDX_GAIN) begin
      r = {1'b1, gain_r};
    end else if (a == `LPCS_IDX_BG_CTRL) begin
      r = {1'b1, bg_ctrl_r};
    end else if (a == `LPCS_IDX_STATUS) begin
      r = {1'b1, stat};
    end
    return r;
  endfunction

  assign idx    = PADDR[11:2];
  assign rd_hit = rd_mux(idx, {5'h00, trig_r, state_r});
  // write lands only on the access edge that samples pready high
  assign wr_go  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

  always_comb begin
    pin_cfg_nxt   = pin_cfg_r;
    soft_trig_nxt = soft_trig_r;
    lp_ctrl_nxt   = lp_ctrl_r;
    gain_nxt      = gain_r;
    bg_ctrl_nxt   = bg_ctrl_r;
    fuse_done_nxt = 1'b1;
    prdata_nxt    = PRDATA;
    pready_nxt    = 1'b0;
    pslverr_nxt   = 1'b0;
    // factory trim taken once, right after reset release
    if (!fuse_done_r) begin
      gain_nxt = FUSE_GAIN;
    end
    if (PSEL && !PENABLE) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = ~rd_hit[8] | (PADDR[1:0] != 2'b00);
      prdata_nxt  = 32'h0000_0000;
      if (!PWRITE && rd_hit[8] && PADDR[1:0] == 2'b00) begin
        prdata_nxt = {24'h00_0000, rd_hit[7:0]};
      end
    end else if (PSEL && PENABLE && !PREADY) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = PSLVERR;
    end
    if (wr_go) begin
      if (idx == `LPCS_IDX_PIN_CFG) begin
        pin_cfg_nxt = PWDATA[7:0];
      end else if (idx == `LPCS_IDX_SOFT_TRIG) begin
        soft_trig_nxt = PWDATA[7:0];
      end else if (idx == `LPCS_IDX_LP_CTRL) begin
        lp_ctrl_nxt = PWDATA[7:0];
      end else if (idx == `LPCS_IDX_GAIN) begin
        gain_nxt = PWDATA[7:0];
      end else if (idx == `LPCS_IDX_BG_CTRL) begin
        bg_ctrl_nxt = PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_cfg_r   <= `LPCS_RST_PIN_CFG;
      soft_trig_r <= `LPCS_RST_SOFT_TRIG;
      lp_ctrl_r   <= `LPCS_RST_LP_CTRL;
      gain_r      <= `LPCS_RST_GAIN;
      bg_ctrl_r   <= `LPCS_RST_BG_CTRL;
      fuse_done_r <= 1'b0;
      PRDATA      <= 32'h0000_0000;
      PREADY      <= 1'b0;
      PSLVERR     <= 1'b0;
    end else begin
      pin_cfg_r   <= pin_cfg_nxt;
      soft_trig_r <= soft_trig_nxt;
      lp_ctrl_r   <= lp_ctrl_nxt;
      gain_r      <= gain_nxt;
      bg_ctrl_r   <= bg_ctrl_nxt;
      fuse_done_r <= fuse_done_nxt;
      PRDATA      <= prdata_nxt;
      PREADY      <= pready_nxt;
      PSLVERR     <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calibration scheduler

  lpcs_cnt_t cnt_r;
  lpcs_cnt_t cnt_nxt;
  logic      lp_active;
  logic      timed_mode;

  function automatic lpcs_cnt_t sleep_len(input logic [2:0] c);
    lpcs_cnt_t n;
    case (c)
      3'h0: n = `LPCS_SLEEP_0;
      3'h1: n = P_SLEEP_1;
      3'h2: n = P_SLEEP_2;
      3'h3: n = P_SLEEP_3;
      3'h4: n = P_SLEEP_4;
      3'h5: n = P_SLEEP_5;
      3'h6: n = P_SLEEP_6;
      default: n = P_SLEEP_7;
    endcase
    return n - 41'd1;
  endfunction

  function automatic lpcs_cnt_t wake_len(input logic [1:0] c);
    lpcs_cnt_t n;
    case (c)
      2'h0: n = `LPCS_WAKE_0;
      2'h1: n = P_WAKE_1;
      2'h2: n = P_WAKE_2;
      default: n = P_WAKE_3;
    endcase
    return n - 41'd1;
  endfunction

  // low power has no effect unless background calibration runs
  assign lp_active  = lp_ctrl_r[`LPCS_LP_ON_BIT] & bg_ctrl_r[`LPCS_BG_ON_BIT];
  assign timed_mode = ~lp_ctrl_r[`LPCS_MODE_BIT];

  always_comb begin
    if (pin_cfg_r[`LPCS_SRC_SEL_BIT]) begin
      trig_nxt = pin_r;
    end else begin
      trig_nxt = soft_trig_r[`LPCS_SOFT_TRIG_BIT];
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!lp_active) begin
      state_nxt = LPCS_IDLE;
      cnt_nxt   = '0;
    end else begin
      case (state_r)
        LPCS_IDLE: begin
          state_nxt = LPCS_SLEEP;
          cnt_nxt   = sleep_len(lp_ctrl_r[`LPCS_SLEEP_HI:`LPCS_SLEEP_LO]);
        end
        LPCS_SLEEP: begin
          if (timed_mode) begin
            if (cnt_r == '0) begin
              state_nxt = LPCS_WAKE;
              cnt_nxt   = wake_len(lp_ctrl_r[`LPCS_WAKE_HI:`LPCS_WAKE_LO]);
            end else begin
              cnt_nxt = cnt_r - 41'd1;
            end
          end else if (!trig_r) begin
            state_nxt = LPCS_WAKE;
            cnt_nxt   = wake_len(lp_ctrl_r[`LPCS_WAKE_HI:`LPCS_WAKE_LO]);
          end
        end
        LPCS_WAKE: begin
          if (cnt_r == '0) begin
            state_nxt = LPCS_CAL;
          end else begin
            cnt_nxt = cnt_r - 41'd1;
          end
        end
        default: begin
          // next offline core goes back to sleep once calibrated
          if (CAL_DONE) begin
            state_nxt = LPCS_SLEEP;
            cnt_nxt   = sleep_len(lp_ctrl_r[`LPCS_SLEEP_HI:`LPCS_SLEEP_LO]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      trig_r       <= 1'b0;
      state_r      <= LPCS_IDLE;
      cnt_r        <= '0;
      CAL_TRIGGER  <= 1'b0;
      CORE_SLEEP   <= 1'b0;
      CORE_SETTLE  <= 1'b0;
      CORE_CAL_REQ <= 1'b0;
      CORE_GAIN    <= `LPCS_RST_GAIN;
    end else begin
      trig_r       <= trig_nxt;
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      CAL_TRIGGER  <= trig_nxt;
      CORE_SLEEP   <= (state_nxt == LPCS_SLEEP);
      CORE_SETTLE  <= (state_nxt == LPCS_WAKE);
      CORE_CAL_REQ <= (state_nxt == LPCS_CAL);
      CORE_GAIN    <= gain_nxt;
    end
  end

endmodule

// ===== verification/lpcs_props.sv
`timescale 1ns/1ps
module lpcs_chk (
  input logic        MCLK,
  input logic        RESETN,
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [31:0] PRDATA,
  input logic        PREADY,
  input logic        PSLVERR,
  input logic        EXTERNAL_TRIGGER_PIN,
  input logic [7:0]  FUSE_GAIN,
  input logic        CAL_DONE,
  input logic        CAL_TRIGGER,
  input logic        CORE_SLEEP,
  input logic        CORE_SETTLE,
  input logic        CORE_CAL_REQ,
  input logic [7:0]  CORE_GAIN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // a bus write may legally drop the scheduler to idle
  wire wr = PSEL && PENABLE && PWRITE;
  AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_RDATA_UPPER: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_ONE_PHASE: assert property ($onehot0({CORE_SLEEP, CORE_SETTLE, CORE_CAL_REQ}))
    else $error("two phases at once");
  AST_SETTLE_ORDER: assert property ($rose(CORE_SETTLE) |-> $past(CORE_SLEEP))
    else $error("settle not after sleep");
  AST_CAL_ORDER: assert property ($rose(CORE_CAL_REQ) |-> $past(CORE_SETTLE))
    else $error("calibration not after settle");
  // a write lands one edge before the phase outputs can react to it
  AST_CAL_HOLD: assert property (CORE_CAL_REQ && !CAL_DONE && !$past(wr) |=> CORE_CAL_REQ)
    else $error("calibration request dropped");
  AST_DONE_ENDS: assert property (CORE_CAL_REQ && CAL_DONE && !wr |=> !CORE_CAL_REQ)
    else $error("calibration request kept after done");
  cover property ($rose(CORE_CAL_REQ));
  cover property (PSLVERR);
  cover property ($fell(CORE_SLEEP) && CORE_SETTLE);
endmodule
bind lpcs_top lpcs_chk u_chk (
  .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EXTERNAL_TRIGGER_PIN(EXTERNAL_TRIGGER_PIN), .FUSE_GAIN(FUSE_GAIN), .CAL_DONE(CAL_DONE),
  .CAL_TRIGGER(CAL_TRIGGER), .CORE_SLEEP(CORE_SLEEP), .CORE_SETTLE(CORE_SETTLE),
  .CORE_CAL_REQ(CORE_CAL_REQ), .CORE_GAIN(CORE_GAIN));

// ===== verification/lpcs_tb.sv
`timescale 1ns/1ps
module testbench;
  logic        MCLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, er, CAL_TRIGGER, CORE_SLEEP, CORE_SETTLE, CORE_CAL_REQ;
  logic        EXTERNAL_TRIGGER_PIN = 1'b0, CAL_DONE = 1'b0;
  logic [7:0]  FUSE_GAIN = 8'h5a, CORE_GAIN;
  int          num_errors = 0, check_count = 0;
  wire  [2:0]  ph = {CORE_CAL_REQ, CORE_SETTLE, CORE_SLEEP};

  always #10 MCLK = ~MCLK;

  // short counts keep the overridden phases measurable in a few hundred cycles;
  // code 0 has no override and runs its full 1152 cycles; other full-length codes are never programmed here
  lpcs_top #(.P_SLEEP_1(41'd60), .P_SLEEP_4(41'd90), .P_SLEEP_7(41'd120),
    .P_WAKE_1(41'd50), .P_WAKE_3(41'd70)) dut (
    .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXTERNAL_TRIGGER_PIN(EXTERNAL_TRIGGER_PIN), .FUSE_GAIN(FUSE_GAIN), .CAL_DONE(CAL_DONE),
    .CAL_TRIGGER(CAL_TRIGGER), .CORE_SLEEP(CORE_SLEEP), .CORE_SETTLE(CORE_SETTLE),
    .CORE_CAL_REQ(CORE_CAL_REQ), .CORE_GAIN(CORE_GAIN));

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [40:0] e, input logic [40:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %0h got %0h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      close_out;
    end
    rd = PRDATA; er = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task wait_ph(input int b, input logic v);
    int n;
    n = 0;
    while (ph[b] !== v) begin
      @(posedge MCLK);
      n++;
      if (n > 3000) begin
        num_errors++;
        close_out;
      end
    end
  endtask

  task len(input int b, output int c);
    c = 0;
    while (ph[b] === 1'b1) begin
      @(posedge MCLK);
      c++;
      if (c > 5000) begin
        num_errors++;
        close_out;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [11:0] a[5] = '{12'h1b8, 12'h1ac, 12'h1b0, 12'h1e8, 12'h080};
    logic [7:0]  v[5] = '{8'h88, 8'h00, 8'h01, 8'h5a, 8'h00};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk("reset value", {24'h0, v[i]}, rd);
    end
    chk("trigger at reset", 1, CAL_TRIGGER);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped err", 1, er);
    apb(1'b0, 12'h1b9, 32'h0);
    chk("misaligned err", 1, er);
    chk("misaligned data", 0, rd);
    apb(1'b1, 12'h1e8, 32'hffff_ffc3);
    repeat (2) @(posedge MCLK);
    chk("gain out", 8'hc3, CORE_GAIN);
  endtask

  task t_pin;
    apb(1'b1, 12'h1b0, 32'h0);
    repeat (2) @(posedge MCLK);
    chk("soft low", 0, CAL_TRIGGER);
    apb(1'b1, 12'h1ac, 32'h1);
    EXTERNAL_TRIGGER_PIN <= 1'b1;
    repeat (8) @(posedge MCLK);
    chk("pin high", 1, CAL_TRIGGER);
    EXTERNAL_TRIGGER_PIN <= 1'b0;
    apb(1'b1, 12'h1b0, 32'h1);
    repeat (8) @(posedge MCLK);
    chk("pin low, soft ignored", 0, CAL_TRIGGER);
    apb(1'b1, 12'h1ac, 32'h0);
  endtask

  task t_timed;
    int c;
    logic [2:0] sc[4] = '{3'd0, 3'd1, 3'd4, 3'd7};
    logic [1:0] wc[4] = '{2'd0, 2'd1, 2'd3, 2'd1};
    int         sn[4] = '{1152, 60, 90, 120};
    int         wn[4] = '{1152, 50, 70, 50};
    apb(1'b1, 12'h080, 32'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h1b8, {24'h0, sc[k], wc[k], 3'b001});
      wait_ph(0, 1'b1);
      len(0, c);
      chk("sleep cycles", sn[k], c);
      wait_ph(1, 1'b1);
      len(1, c);
      chk("settle cycles", wn[k], c);
      wait_ph(2, 1'b1);
      repeat (3) @(posedge MCLK);
      CAL_DONE <= 1'b1;
      @(posedge MCLK);
      CAL_DONE <= 1'b0;
      @(posedge MCLK);
      chk("sleep again", 1, CORE_SLEEP);
      apb(1'b1, 12'h1b8, 32'h0);
    end
  endtask

  task t_trig;
    int c;
    // trigger held high by the soft bit: sleep must outlast the timed count
    apb(1'b1, 12'h1b8, 32'h8b);
    repeat (300) @(posedge MCLK);
    chk("held asleep", 1, CORE_SLEEP);
    apb(1'b0, 12'h084, 32'h0);
    chk("status asleep", 32'h5, rd);
    apb(1'b1, 12'h1b0, 32'h0);
    wait_ph(1, 1'b1);
    len(1, c);
    chk("trig settle", 50, c);
    apb(1'b1, 12'h1b8, 32'h0);
    apb(1'b1, 12'h1b0, 32'h1);
  endtask

  task t_nobg;
    apb(1'b1, 12'h080, 32'h0);
    apb(1'b1, 12'h1b8, 32'h1);
    repeat (5) @(posedge MCLK);
    chk("no bg no sleep", 0, ph);
  endtask

  initial begin
    repeat (16) @(posedge MCLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_regs;
    t_pin;
    t_timed;
    t_trig;
    t_nobg;
    close_out;
  end
endmodule
